// ### hdl/ebm_defines.svh
// Constants for the external bus master port: widths, size codes, region codes.
// Assumes inclusion by the bus port module and the bench; definitions only.
`ifndef EBM_DEFINES_SVH
`define EBM_DEFINES_SVH

`define EBM_ADDR_W        24
`define EBM_CS_NUM        8
`define EBM_BOOT_CS       3'h0
`define EBM_SDR_CS_LO     3'h2
`define EBM_SDR_CS_HI     3'h3
// Port width codes, also the boot strap code
`define EBM_PS_32         2'h0
`define EBM_PS_8          2'h1
`define EBM_PS_16         2'h2
`define EBM_PS_RESV       2'h3
// Access size codes
`define EBM_SZ_LONG       2'h0
`define EBM_SZ_BYTE       2'h1
`define EBM_SZ_WORD       2'h2
// Region codes of the requested address
`define EBM_RGN_EXT       2'h0
`define EBM_RGN_PERIPH    2'h1
`define EBM_RGN_ONCHIP    2'h2

`endif

// ### hdl/ebm_pkg.sv
// Types used by the external bus master port.
// Assumes nothing beyond a SystemVerilog compiler.
package ebm_pkg;

    typedef enum logic [2:0] {
        EBM_IDLE  = 3'b000,
        EBM_START = 3'b001,
        EBM_WAIT  = 3'b010,
        EBM_NEXT  = 3'b011,
        EBM_DONE  = 3'b100
    } ebm_state_t;

endpackage

// ### hdl/ebm_bus_port.sv
// External bus master port for SRAM, Flash and memory-mapped peripherals.
// Assumes one 10 MHz clock, slave inputs synchronous to it, a pad ring that
// resolves the data bus from data_oe, and a core that holds a request stable.
//
// Notes on behaviour
// [R1] SRAM and peripheral cycles drive a strobe low per byte lane in use.
// [R2] Only strobes of bytes involved in the access are asserted.
// [R3] Strobe 0 is the most significant lane, strobe 3 the least.
// [R4] Strobes assert for on-chip peripherals, never for on-chip SRAM or cache.
// [R5] SDRAM cycles use strobes as active-high byte column strobes and masks.
// [R6] Output enable asserts during external read cycles, except SDRAM reads.
// [R7] Read ends on transfer acknowledge after the data bus is captured.
// [R8] Write ends on transfer acknowledge.
// [R9] Error acknowledge ends the cycle and raises an access error.
// [R10] Direction output is high for reads and low for writes.
// [R11] Each chip select has its own port width of 8, 16 or 32 bits.
// [R12] Size strap at reset sets the boot chip select port width.
// [R13] Software sets other port widths before using their space.
// [R14] Transfer start marks the first cycle of each transfer.
// [R15] Transfer-in-progress holds while a transfer is under way.
// [R16] Eight chip selects; the target's one asserts per transaction.
// [R17] Chip selects 3 and 2 may serve as the SDRAM bank selects.
// [R18] With a 16-bit bus the low data lines are released for GPIO.
// [R19] Address outputs carry the low 24 bits of the address.
// [R20] Data bus is driven on writes and released on reads.
// [R21] Acknowledges are sampled each edge; the cycle waits until one is seen.
//
// Usage and limits
// - The core holds req_* steady from request to the ready pulse.
// - req_valid must drop on the ready cycle, or the access repeats.
// - Every beat is a start cycle, then wait cycles until acknowledge.
// - One idle cycle separates the beats of a dynamically sized access.
// - No wait-state counter: a slave that never answers hangs the port.
// - An error acknowledge wins over a done acknowledge in the same cycle.
// - An error stops the access; later beats are not run.
// - On-chip memory requests finish without moving any pin.
// - On-chip peripheral requests drive strobes but no chip select.
// - The width table is loaded whole; partial updates are the core's job.
// - Width code 3 is treated as 32 bits.
// - SDRAM command sequencing lives elsewhere; only selects and strobes
//   are shared with it here.
// - Pins are registered, so they settle one clock after the decision.
`timescale 1ns/100ps
`include "ebm_defines.svh"

module ebm_bus_port (
    input  wire logic        sys_clk,          // 10 MHz bus clock
    input  wire logic        arst_n,           // Asynchronous reset, active low
    input  wire logic        req_valid,        // Core requests an access
    output logic             req_ready,        // Access finished, one-cycle pulse
    input  wire logic [31:0] req_addr,         // Byte address
    input  wire logic        req_read,         // 1 read, 0 write
    input  wire logic [1:0]  req_size,         // Access size code
    input  wire logic [1:0]  req_region,       // External, on-chip periph, on-chip mem
    input  wire logic [2:0]  req_cs,           // Decoded chip select number
    input  wire logic        req_sdram,        // Access goes to an SDRAM bank
    input  wire logic [31:0] req_wdata,        // Write data, big-endian lanes
    output logic [31:0]      rsp_rdata,        // Read data, valid with req_ready
    output logic             rsp_error,        // Access error, with req_ready
    input  wire logic [15:0] cs_width_cfg,     // Two bits of port width per chip select
    input  wire logic        cs_width_wr,      // Load cs_width_cfg into the width table
    input  wire logic        sdram_cs_en,      // Chip selects 3:2 act as SDRAM banks
    input  wire logic        bus16_gpio_en,    // Low data lines freed in 16-bit mode
    input  wire logic [1:0]  size_strap,       // Boot width straps, held during reset
    output logic [23:0]      addr_out,         // Address outputs
    output logic [7:0]       chip_select_n,    // Chip selects, active low
    output logic [1:0]       sdram_bank_select,// SDRAM bank selects, active low
    output logic             sdram_write_strobe,// SDRAM write enable, active low
    output logic [3:0]       byte_lane_strobe_n,// Byte strobes, lane 0 is MSB
    output logic             out_enable_n,     // Output enable, active low
    output logic             rd_wr,            // 1 read, 0 write
    output logic             xfer_begin_n,     // Transfer start, active low
    output logic             xfer_active_n,    // Transfer in progress, active low
    input  wire logic        xfer_done_ack_n,  // Transfer acknowledge, active low
    input  wire logic        xfer_error_ack_n, // Transfer error acknowledge, active low
    input  wire logic [31:0] data_in,          // Data bus input side
    output logic [31:0]      data_out,         // Data bus output side
    output logic [31:0]      data_oe,          // Per-line drive enable
    output logic             gpio_low_free     // Low 16 data lines belong to GPIO
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic       rst_meta_reg;
    logic       rst_n_reg;

    // Release passes two flops so that the sequencer and the width table come out of reset on a clock edge.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Port width table
    // ------------------------------------------------------------------
    // Two bits per chip select; chip select 0 is the boot select.
    // Only the boot entry is loaded from the straps; the others stay at the
    // 32-bit code until the core loads the table.
    //
    // Straps are caught by a clocked process while reset is still held, so the
    // flops never load a port value asynchronously.
    logic [15:0] width_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            width_reg <= 16'h0000;
        end else if (!rst_n_reg) begin
            width_reg[1:0] <= size_strap;                          // [R12]
        end else if (cs_width_wr) begin
            width_reg <= cs_width_cfg;                             // [R11]
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Small decoders shared by the sequencer, the capture and the drivers.
    //
    // Bytes the current beat moves on a port of the given width
    function automatic logic [2:0] beat_bytes(input logic [1:0] ps, input logic [2:0] left);
        logic [2:0] cap;
        cap = (ps == `EBM_PS_8) ? 3'h1 : (ps == `EBM_PS_16) ? 3'h2 : 3'h4;
        beat_bytes = (left < cap) ? left : cap;
    endfunction

    // Lane mask, bit 3 = lane 0 (MSB); offset counts from the MSB lane
    function automatic logic [3:0] lane_mask(input logic [1:0] off, input logic [2:0] n);
        logic [3:0] m;
        m = (n == 3'h1) ? 4'h8 : (n == 3'h2) ? 4'hc : 4'hf;
        lane_mask = m >> off;
    endfunction

    function automatic logic [2:0] size_bytes(input logic [1:0] sz);
        size_bytes = (sz == `EBM_SZ_BYTE) ? 3'h1 : (sz == `EBM_SZ_WORD) ? 3'h2 : 3'h4;
    endfunction

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    ebm_pkg::ebm_state_t state_reg;
    ebm_pkg::ebm_state_t state_next;
    logic [31:0] addr_reg;
    logic [2:0]  left_reg;
    logic [2:0]  cur_n;
    logic [1:0]  port_w;
    logic [1:0]  off;
    logic        ack_seen;
    logic        err_seen;
    logic        is_ext;
    logic [31:0] cur_addr;
    logic [2:0]  cur_left;
    logic [3:0]  lanes;

    // The first beat is launched from the request itself, before addr_reg
    // and left_reg are loaded; reading them then would replay the last access.
    assign cur_addr = (state_reg == ebm_pkg::EBM_IDLE) ? req_addr : addr_reg;
    assign cur_left = (state_reg == ebm_pkg::EBM_IDLE) ? size_bytes(req_size)
                                                       : left_reg;

    // Width of the selected chip select's port
    assign port_w   = width_reg[{req_cs, 1'b0} +: 2];
    // SDRAM is always a full-width port
    assign cur_n    = beat_bytes(req_sdram ? `EBM_PS_32 : port_w, cur_left);
    assign ack_seen = !xfer_done_ack_n;                            // [R21]
    assign err_seen = !xfer_error_ack_n;                           // [R21]
    // Port byte address within the lane group depends on port width
    assign off      = (port_w == `EBM_PS_8 && !req_sdram) ? 2'h0 :
                      (port_w == `EBM_PS_16 && !req_sdram) ? {1'b0, cur_addr[0]} :
                      cur_addr[1:0];
    // On-chip memory and cache hits never reach the pins
    assign is_ext   = (req_region != `EBM_RGN_ONCHIP);             // [R4]

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ebm_pkg::EBM_IDLE:  if (req_valid && is_ext) begin
                state_next = ebm_pkg::EBM_START;
            end else if (req_valid) begin
                state_next = ebm_pkg::EBM_DONE;
            end
            ebm_pkg::EBM_START: state_next = ebm_pkg::EBM_WAIT;
            ebm_pkg::EBM_WAIT:  if (err_seen) begin
                state_next = ebm_pkg::EBM_DONE;                    // [R9]
            end else if (ack_seen) begin
                state_next = (left_reg == cur_n) ? ebm_pkg::EBM_DONE
                                                 : ebm_pkg::EBM_NEXT; // [R7] [R8]
            end
            ebm_pkg::EBM_NEXT:  state_next = ebm_pkg::EBM_START;
            ebm_pkg::EBM_DONE:  state_next = ebm_pkg::EBM_IDLE;
            default:            state_next = ebm_pkg::EBM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ebm_pkg::EBM_IDLE;
        end else if (!rst_n_reg) begin
            state_reg <= ebm_pkg::EBM_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end


    // Address and remaining byte count advance per beat (dynamic sizing)
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_reg <= 32'h0000_0000;
            left_reg <= 3'h0;
        end else if (state_reg == ebm_pkg::EBM_IDLE && req_valid) begin
            addr_reg <= req_addr;
            left_reg <= size_bytes(req_size);
        end else if (state_reg == ebm_pkg::EBM_WAIT && ack_seen && !err_seen) begin
            addr_reg <= addr_reg + {29'h0, cur_n};                 // [R11]
            left_reg <= left_reg - cur_n;
        end
    end

    // ------------------------------------------------------------------
    // Read data capture and error
    // ------------------------------------------------------------------
    // Narrow ports return data on the high lanes; it is moved to its place in
    // the big-endian word of the request.
    // dst is the byte index of the current beat within the requested word.
    logic [1:0] dst;
    assign dst = cur_addr[1:0] - req_addr[1:0];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_rdata <= 32'h0000_0000;
            rsp_error <= 1'b0;
        end else if (state_reg == ebm_pkg::EBM_IDLE && req_valid) begin
            rsp_error <= 1'b0;
        end else if (state_reg == ebm_pkg::EBM_WAIT && err_seen) begin
            rsp_error <= 1'b1;                                     // [R9]
        end else if (state_reg == ebm_pkg::EBM_WAIT && ack_seen && req_read) begin
            for (int i = 0; i < 4; i++) begin
                if (lanes[3 - i]) begin
                    rsp_rdata[8 * (3 - ((i - off + dst) & 3)) +: 8]
                        <= data_in[8 * (3 - i) +: 8];              // [R7]
                end
            end
        end
    end


    // Ready is decoded from the state so it lines up with the data flops.
    assign req_ready = (state_reg == ebm_pkg::EBM_DONE);

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    logic busy;
    logic [2:0] src;
    logic [3:0] strobe_lanes;
    assign busy  = (state_reg == ebm_pkg::EBM_START) || (state_reg == ebm_pkg::EBM_WAIT);
    assign lanes = lane_mask(off, cur_n);
    assign src   = {1'b0, dst};

    // The mask keeps the MSB lane in bit 3, but strobe bit 0 owns the
    // MSB lane on the pins, so the order is reversed here.
    assign strobe_lanes = {lanes[0], lanes[1], lanes[2], lanes[3]};   // [R3]

    // Pins follow state_next, so they change on the same edge as the
    // state and stand from the start cycle through the acknowledge cycle.

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_out           <= 24'h00_0000;
            chip_select_n      <= 8'hff;
            sdram_bank_select  <= 2'h3;
            sdram_write_strobe <= 1'b1;
            byte_lane_strobe_n <= 4'hf;
            out_enable_n       <= 1'b1;
            rd_wr              <= 1'b1;
            xfer_begin_n       <= 1'b1;
            xfer_active_n      <= 1'b1;
            data_out           <= 32'h0000_0000;
            data_oe            <= 32'h0000_0000;
            gpio_low_free      <= 1'b0;
        end else begin
            gpio_low_free <= bus16_gpio_en;                        // [R18]
            xfer_begin_n  <= !(state_next == ebm_pkg::EBM_START); // [R14]
            xfer_active_n <= !(state_next == ebm_pkg::EBM_START ||
                               state_next == ebm_pkg::EBM_WAIT);   // [R15] [R21]
            if (state_next == ebm_pkg::EBM_START || state_next == ebm_pkg::EBM_WAIT) begin
                addr_out <= (state_reg == ebm_pkg::EBM_IDLE) ? req_addr[23:0]
                                                             : addr_reg[23:0]; // [R19]
                rd_wr    <= req_read;                              // [R10]
                chip_select_n <= 8'hff;
                sdram_bank_select <= 2'h3;
                if (req_region == `EBM_RGN_EXT) begin
                    if (req_sdram && sdram_cs_en &&
                        (req_cs == `EBM_SDR_CS_LO || req_cs == `EBM_SDR_CS_HI)) begin
                        sdram_bank_select[req_cs[0]] <= 1'b0;      // [R17]
                    end else begin
                        chip_select_n[req_cs] <= 1'b0;             // [R16]
                    end
                end
                sdram_write_strobe <= !(req_sdram && !req_read);   // [R10]
                // SDRAM takes active-high lane strobes
                byte_lane_strobe_n <= req_sdram ? strobe_lanes
                                                : ~strobe_lanes;   // [R1] [R2] [R3] [R5]
                out_enable_n <= !(req_read && !req_sdram);         // [R6]
                for (int i = 0; i < 4; i++) begin
                    data_out[8 * (3 - i) +: 8] <=
                        req_wdata[8 * (3 - ((i - off + src) & 3)) +: 8];
                    data_oe[8 * (3 - i) +: 8] <=
                        (!req_read && lanes[3 - i] &&
                         !(bus16_gpio_en && i > 1)) ? 8'hff : 8'h00; // [R20] [R18]
                end
            end else begin
                // Between beats everything returns to idle; the address
                // and write data are left as they were to save toggling.
                chip_select_n      <= 8'hff;
                sdram_bank_select  <= 2'h3;
                sdram_write_strobe <= 1'b1;
                byte_lane_strobe_n <= 4'hf;
                out_enable_n       <= 1'b1;
                rd_wr              <= 1'b1;
                data_oe            <= 32'h0000_0000;               // [R20]
            end
        end
    end

endmodule // ebm_bus_port

// ### tb/ebm_bus_port_properties.sv
// Concurrent checks on the pins of the external bus master port.
// Assumes it is bound into ebm_bus_port and sees only its ports.
`timescale 1ns/100ps
module ebm_bus_port_props (
    input wire logic        sys_clk,            // Bus clock
    input wire logic        arst_n,             // Reset, active low
    input wire logic        req_ready,          // Access done pulse
    input wire logic        rsp_error,          // Access error
    input wire logic [7:0]  chip_select_n,      // Chip selects
    input wire logic [3:0]  byte_lane_strobe_n, // Byte strobes
    input wire logic        out_enable_n,       // Output enable
    input wire logic        rd_wr,              // Direction
    input wire logic        sdram_write_strobe, // SDRAM write enable
    input wire logic        xfer_begin_n,       // Transfer start
    input wire logic        xfer_active_n,      // Transfer in progress
    input wire logic        xfer_done_ack_n,    // Slave acknowledge
    input wire logic        xfer_error_ack_n,   // Slave error acknowledge
    input wire logic [31:0] data_oe             // Data drive enables
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_begin_in_beat: assert property (!xfer_begin_n |-> !xfer_active_n)
        else $error("transfer start outside a transfer");
    chk_begin_one_cycle: assert property ($fell(xfer_begin_n) |=> xfer_begin_n)
        else $error("transfer start longer than one cycle");
    chk_active_until_ack: assert property (
        !xfer_active_n && xfer_done_ack_n && xfer_error_ack_n |=> !xfer_active_n)
        else $error("transfer ended without acknowledge");
    chk_ack_ends_beat: assert property (
        !xfer_active_n && xfer_begin_n && !xfer_done_ack_n |=> xfer_active_n)
        else $error("acknowledge did not end the beat");
    chk_error_ends_access: assert property (
        !xfer_active_n && xfer_begin_n && !xfer_error_ack_n
        |=> xfer_active_n && req_ready && rsp_error)
        else $error("error acknowledge not reported");
    chk_oe_on_read: assert property (!out_enable_n |-> rd_wr && !xfer_active_n)
        else $error("output enable outside a read");
    chk_drive_on_write: assert property (data_oe != 32'h0 |-> !rd_wr)
        else $error("data bus driven during a read");
    chk_one_select: assert property (
        chip_select_n != 8'hff |-> $onehot(~chip_select_n) && !xfer_active_n)
        else $error("chip select wrong count or outside transfer");
    chk_strobes_idle: assert property (xfer_active_n |-> byte_lane_strobe_n == 4'hf)
        else $error("byte strobe outside a transfer");

    cov_error: cover property (!xfer_error_ack_n && !xfer_active_n && xfer_begin_n);
    cov_read: cover property ($fell(xfer_begin_n) && rd_wr);
    cov_sdram_write: cover property (!sdram_write_strobe && !xfer_active_n);
endmodule // ebm_bus_port_props

bind ebm_bus_port ebm_bus_port_props u_ebm_bus_port_props (.*);

// ### tb/ebm_slave_model.sv
// Byte-wide memory slave on the external bus with programmable wait.
// Assumes strobes and address stand until the acknowledge is sampled.
`timescale 1ns/100ps
module ebm_slave_model (
    input wire logic        sys_clk,            // Bus clock
    input wire logic [31:0] wait_cyc,           // Cycles until acknowledge
    input wire logic        err_mode,           // Answer with error acknowledge
    input wire logic [23:0] addr_out,           // Address
    input wire logic [3:0]  byte_lane_strobe_n, // Byte strobes
    input wire logic        out_enable_n,       // Read enable
    input wire logic        rd_wr,              // Direction
    input wire logic        xfer_active_n,      // Transfer in progress
    input wire logic [31:0] data_in,            // Resolved data bus
    output logic            xfer_done_ack_n,    // Acknowledge
    output logic            xfer_error_ack_n,   // Error acknowledge
    output logic [31:0]     slave_d             // Slave drive of the bus
);
    logic [7:0]  mem [64];
    logic [31:0] cnt = 0;
    logic [31:0] last = 0;
    logic [31:0] rdv;
    int          fl;

    initial begin
        foreach (mem[i]) mem[i] = 8'h0;
        xfer_done_ack_n = 1'b1;
        xfer_error_ack_n = 1'b1;
    end

    // Lowest strobed lane holds the addressed byte on any port width
    always_comb begin
        fl = 0;
        for (int i = 3; i >= 0; i--) if (!byte_lane_strobe_n[i]) fl = i;
        for (int i = 0; i < 4; i++) rdv[31-8*i -: 8] = mem[addr_out[5:0] + 6'(i - fl)];
    end
    // Released bus shows the inverse of the last value, not a stale copy
    assign slave_d = out_enable_n ? ~last : rdv;

    always @(posedge sys_clk) begin
        if (!out_enable_n) last <= rdv;
        if (!xfer_done_ack_n && !rd_wr)
            for (int i = 0; i < 4; i++)
                if (!byte_lane_strobe_n[i]) mem[addr_out[5:0] + 6'(i - fl)] <= data_in[31-8*i -: 8];
        if (!xfer_active_n && xfer_done_ack_n && xfer_error_ack_n) begin
            cnt <= cnt + 1;
            if (cnt + 1 == wait_cyc) begin
                xfer_done_ack_n <= err_mode;
                xfer_error_ack_n <= !err_mode;
            end
        end else begin
            cnt <= 0;
            xfer_done_ack_n <= 1'b1;
            xfer_error_ack_n <= 1'b1;
        end
    end
endmodule // ebm_slave_model

// ### tb/tb.sv
// Self-checking bench for the external bus master port.
// Assumes the design, the slave model and the checker compile first.
`timescale 1ns/100ps
`include "ebm_defines.svh"
module tb;
    logic        sys_clk = 0, arst_n = 0, req_valid = 0, req_read = 0, req_sdram = 0;
    logic        cs_width_wr = 0, sdram_cs_en = 0, bus16_gpio_en = 0, err_mode = 0;
    logic [31:0] req_addr = 0, req_wdata = 0, wait_cyc = 1, data_in, rsp_rdata;
    logic [31:0] data_out, data_oe, slave_d, rdata, doe;
    logic [1:0]  req_size = 0, req_region = 0, size_strap = `EBM_PS_8, sdram_bank_select;
    logic [2:0]  req_cs = 0, sb;
    logic [15:0] cs_width_cfg = 0;
    logic [23:0] addr_out;
    logic [7:0]  chip_select_n, csn;
    logic [3:0]  byte_lane_strobe_n, st, anyst;
    logic        req_ready, rsp_error, sdram_write_strobe, out_enable_n, rd_wr, xfer_begin_n;
    logic        xfer_active_n, xfer_done_ack_n, xfer_error_ack_n, gpio_low_free, oen, rw, err;
    int          beats, n, err_total = 0, total_checks = 0;

    assign data_in = (data_oe & data_out) | (~data_oe & slave_d);
    ebm_bus_port u_ebm_bus_port (.*);
    ebm_slave_model u_ebm_slave_model (.*);

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Bus access and compare
    // ------------------------------------------------------------
    task automatic acc(input logic [31:0] a, input logic rd, input logic [1:0] sz, rg,
                       input logic [2:0] cs, input logic sd, input logic [31:0] wd);
        @(negedge sys_clk);
        {req_addr, req_read, req_size, req_region, req_cs, req_sdram} = {a, rd, sz, rg, cs, sd};
        req_wdata = wd;
        req_valid = 1'b1;
        beats = 0;
        n = 0;
        anyst = 4'hf;
        do begin
            @(negedge sys_clk);
            n++;
            anyst = anyst & byte_lane_strobe_n;
            if (!xfer_begin_n && beats++ == 0)
                {st, csn, oen, rw, sb, doe} = {byte_lane_strobe_n, chip_select_n, out_enable_n,
                                          rd_wr, sdram_bank_select, sdram_write_strobe,
                                          data_oe};
        end while (req_ready !== 1'b1 && n < 200);
        if (req_ready !== 1'b1) chk(32'h0, 32'h1);
        {rdata, err} = {rsp_rdata, rsp_error};
        req_valid = 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_boot();
        acc(32'h0, 1'b1, `EBM_SZ_LONG, `EBM_RGN_EXT, 3'h0, 1'b0, 32'h0);
        chk(32'(beats), 32'h4);
        chk(32'(st), 32'he);
        $display("boot width test done");
    endtask

    task automatic t_lanes();
        @(negedge sys_clk);
        cs_width_cfg = 16'h0001;
        cs_width_wr = 1'b1;
        @(negedge sys_clk);
        cs_width_wr = 1'b0;
        for (int k = 0; k < 4; k++) begin
            acc(32'h24 + k, 1'b0, `EBM_SZ_BYTE, `EBM_RGN_EXT, 3'h1, 1'b0, {4{8'h10 + 8'(k)}});
            chk(32'(st), {28'h0, ~(4'h1 << k)});
        end
        wait_cyc = 3;
        acc(32'h24, 1'b1, `EBM_SZ_LONG, `EBM_RGN_EXT, 3'h1, 1'b0, 32'h0);
        chk(rdata, 32'h10111213);
        chk({oen, rw}, 32'h1);
        acc(32'h20, 1'b0, `EBM_SZ_LONG, `EBM_RGN_EXT, 3'h1, 1'b0, 32'hcafe0123);
        chk({csn, rw, oen}, {8'hfd, 2'b01});
        acc(32'h20, 1'b1, `EBM_SZ_LONG, `EBM_RGN_EXT, 3'h1, 1'b0, 32'h0);
        chk(rdata, 32'hcafe0123);
        wait_cyc = 1;
        $display("byte lane test done");
    endtask

    task automatic t_error_region();
        err_mode = 1'b1;
        acc(32'h28, 1'b1, `EBM_SZ_LONG, `EBM_RGN_EXT, 3'h1, 1'b0, 32'h0);
        chk(32'(err), 32'h1);
        err_mode = 1'b0;
        acc(32'h30, 1'b1, `EBM_SZ_LONG, `EBM_RGN_ONCHIP, 3'h1, 1'b0, 32'h0);
        chk({beats[3:0], anyst}, 32'hf);
        acc(32'h30, 1'b0, `EBM_SZ_BYTE, `EBM_RGN_PERIPH, 3'h1, 1'b0, 32'h0);
        chk({csn, st}, 32'hffe);
        $display("error and region test done");
    endtask

    task automatic t_sdram_gpio();
        sdram_cs_en = 1'b1;
        acc(32'h31, 1'b0, `EBM_SZ_BYTE, `EBM_RGN_EXT, 3'h3, 1'b1, 32'h0);
        chk({st, sb, rw}, {4'h2, 3'b010, 1'b0});
        sdram_cs_en = 1'b0;
        bus16_gpio_en = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(32'(gpio_low_free), 32'h1);
        acc(32'h20, 1'b0, `EBM_SZ_LONG, `EBM_RGN_EXT, 3'h1, 1'b0, 32'h0);
        chk(doe, 32'hffff0000);
        bus16_gpio_en = 1'b0;
        $display("sdram and gpio test done");
    endtask

    initial begin
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_boot();
        t_lanes();
        t_error_region();
        t_sdram_gpio();
        finish_test();
    end

    // Whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end
endmodule // tb
